//--- cmoc_pkg.sv
// Constants, types and reset state for the cell monitor operation control.
// Assumes a single 25 MHz clock and an AXI4-Lite master on the same clock.
// Operation
// (RL1) Stay idle after reset until a request.
// (RL2) Standard run: six cell voltages plus temperature.
// (RL3) Calibration shorts each channel input to itself.
// (RL4) Completion sets result ready and interrupt.
// (RL5) Burst read returns all seven results.
// (RL6) Select a channel, then read its result.
// (RL7) No new start while completion unacknowledged.
// (RL8) Status read acknowledges and drops interrupt.
// (RL9) Writing no operation aborts, no flag raised.
// (RL10) Operation state: running, aborted, ended, none.
// (RL11) One discharge bit per cell channel.
// (RL12) Timer counts on internal 50 kHz tick.
// (RL13) Timer elapse interrupts unless masked.
// (RL14) Timer off after reset; runs when enabled.
// (RL15) Shorter period below count restarts timer.
// (RL16) Timer restart bit clears; runs only enabled.
// (RL17) Host masks timer interrupt on chained devices.
// (RL18) Voltages below threshold raise masked interrupt.
// (RL19) Threshold resets to the 1.5 V code.
// (RL20) Status read clears; rearm after leaving undervoltage.
// (RL21) Request field: 1 starts, 0 stops.
// (RL22) Mode: 00 all, 01 voltages, 1X temperature.
// (RL23) Timer flag and interrupt hold until status read.
package cmoc_pkg;
   localparam int AXI_AW = 12; // Byte address width of the register bus
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'h01;
   localparam logic [7:0] IDX_OPER = 8'h02;
   localparam logic [7:0] IDX_OPSTAT = 8'h03;
   localparam logic [7:0] IDX_RSTR = 8'h04;
   localparam logic [7:0] IDX_MASK = 8'h05;
   localparam logic [7:0] IDX_STATUS = 8'h06;
   localparam logic [7:0] IDX_UDVSTAT = 8'h08;
   localparam logic [7:0] IDX_DISCH = 8'h09;
   localparam logic [7:0] IDX_RDSEL = 8'h0A;
   localparam logic [7:0] IDX_LFT = 8'h0B;
   localparam logic [7:0] IDX_THRESH = 8'h10;
   localparam logic [7:0] IDX_SINGLE = 8'h11;
   localparam logic [7:0] IDX_BURST = 8'h7F; // Four words from here
   localparam int BURST_WORDS = 4;
   // Field positions
   localparam int CTRL_LFT_EN = 3;
   localparam int OPER_RQ = 0;
   localparam int OPER_VM = 1; // Two bits
   localparam int OPER_TM = 3;
   localparam int OPER_OM = 4; // Two bits
   localparam int RSTR_LFT = 0;
   localparam int STAT_RDY = 0;
   localparam int STAT_LFT = 1;
   localparam int STAT_UDV = 2;
   localparam logic [7:0] IRQ_SRC = 8'h07;
   // Reset values and codes
   localparam logic [7:0] OPER_RESET = 8'h02;
   localparam logic [1:0] VM_CAL = 2'h0;
   localparam logic [1:0] OM_VOLT = 2'h1;
   localparam logic [2:0] CH_TEMP = 3'h6;
   localparam logic [2:0] CH_LAST_V = 3'h5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Undervoltage default of 1500 mV at 1000 uV per code
   localparam int UDV_DEFAULT_MV = 1500;
   localparam int ADC_LSB_UV = 1000;
   localparam logic [15:0] THRESH_RESET =
      16'(UDV_DEFAULT_MV * 1000 / ADC_LSB_UV);
   // Timer tick: 20000 ns oscillator period over a 40 ns clock
   localparam int OSC_PERIOD_NS = 20000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
   typedef enum logic [1:0]
   {
      OPS_NONE = 2'h0, OPS_RUN = 2'h1, OPS_ABORT = 2'h2, OPS_END = 2'h3
   } cmoc_ops_e;
   typedef enum logic [1:0]
   {
      SQ_IDLE = 2'h0, SQ_CONV = 2'h1, SQ_DONE = 2'h3
   } cmoc_seq_e;
   // Request to the converter front end
   typedef struct packed {
      logic req;      // Held until acknowledged
      logic [2:0] chan; // 0..5 cells, 6 temperature
      logic cal;      // Inputs shorted for offset measurement
      logic temp_sel; // Second temperature input
   } cmoc_adc_s;
   // All state of the block
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [AXI_AW-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [7:0] ctrl;
      logic [7:0] oper;
      cmoc_ops_e op_state;
      logic [7:0] irq_mask;
      logic [7:0] status;
      logic [5:0] udv_chan;
      logic armed;
      logic [5:0] disch;
      logic [2:0] rdsel;
      logic [7:0] lft_period;
      logic [7:0] lft_cnt;
      logic [9:0] pre_cnt;
      logic [15:0] thresh;
      logic [6:0][15:0] res;
      cmoc_seq_e seq;
      logic [1:0] mode;
      cmoc_adc_s adc;
      logic irq;
   } cmoc_state_s;
   // State after reset
   function automatic cmoc_state_s state_reset();
      cmoc_state_s r;
      r = '0;
      r.awready = 1'b1;
      r.wready = 1'b1;
      r.arready = 1'b1;
      r.oper = OPER_RESET;
      r.armed = 1'b1;
      r.thresh = THRESH_RESET;
      r.seq = SQ_IDLE;
      r.op_state = OPS_NONE;
      return r;
   endfunction : state_reset
endpackage : cmoc_pkg

//--- cmoc_top.sv
// Operation control with AXI4-Lite register slave, sequencer, timer.
// Assumes the converter front end and the bus master share clk.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module cmoc_top #(
   parameter int TICK_CYCLES = cmoc_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [cmoc_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [cmoc_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output cmoc_pkg::cmoc_adc_s adc,
   input wire logic adc_ack,
   input wire logic [15:0] adc_data,
   output logic [5:0] discharge,
   output logic irq
);
   // Tick divider must fit its ten-bit counter
   if (TICK_CYCLES < 2 || TICK_CYCLES > 1024)
   begin : g_bad_tick
      $error("TICK_CYCLES out of range");
   end
   localparam logic [9:0] TICK_LAST = 10'(TICK_CYCLES - 1);

   cmoc_pkg::cmoc_state_s s; // Registered state
   cmoc_pkg::cmoc_state_s next_s; // Next state
   logic rd_hs; // Read address taken
   logic do_wr; // Write executes this cycle
   logic stat_rd; // Status read this cycle
   logic wr_oper; // Operation register written
   logic wr_lft; // Timer period written
   logic wr_rstr; // Reset register written
   logic [7:0] wbyte; // Low write byte
   logic [5:0] under; // Cells below threshold

   // Byte address of a register index
   function automatic logic hit(input logic [cmoc_pkg::AXI_AW-1:0] a,
                                input logic [7:0] idx);
      hit = (a == cmoc_pkg::AXI_AW'({idx, 2'b00}));
   endfunction : hit

   // Merge a write byte under its strobe
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] val,
                                        input logic en);
      merge = en ? val : old;
   endfunction : merge

   // Cells whose result lies under the threshold
   function automatic logic [5:0] below(input logic [6:0][15:0] r,
                                        input logic [15:0] t);
      logic [5:0] m;
      m = '0;
      for (int i = 0; i < 6; i++)
      begin
         m[i] = (r[i] < t);
      end
      below = m;
   endfunction : below

   // Next state of the whole block
   always_comb
   begin
      next_s = s;
      wbyte = s.wdata[7:0];
      rd_hs = s.arready && s_axi_arvalid;
      do_wr = s.aw_got && s.w_got && !s.bvalid;
      stat_rd = rd_hs && hit(s_axi_araddr, cmoc_pkg::IDX_STATUS);
      wr_oper = 1'b0;
      wr_lft = 1'b0;
      wr_rstr = 1'b0;
      under = below(s.res, s.thresh);
      // Capture write address and data in either order
      if (s.awready && s_axi_awvalid)
      begin
         next_s.awaddr = s_axi_awaddr;
         next_s.aw_got = 1'b1;
         next_s.awready = 1'b0;
      end
      if (s.wready && s_axi_wvalid)
      begin
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
         next_s.w_got = 1'b1;
         next_s.wready = 1'b0;
      end
      // Write decode once both halves are held
      if (do_wr)
      begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = cmoc_pkg::RESP_OKAY;
         if (hit(s.awaddr, cmoc_pkg::IDX_CTRL))
         begin
            next_s.ctrl = merge(s.ctrl, wbyte, s.wstrb[0]);
         end
         else if (hit(s.awaddr, cmoc_pkg::IDX_OPER))
         begin
            wr_oper = s.wstrb[0];
         end
         else if (hit(s.awaddr, cmoc_pkg::IDX_RSTR))
         begin
            wr_rstr = s.wstrb[0];
         end
         else if (hit(s.awaddr, cmoc_pkg::IDX_MASK))
         begin
            next_s.irq_mask = merge(s.irq_mask, wbyte, s.wstrb[0]);
         end
         else if (hit(s.awaddr, cmoc_pkg::IDX_DISCH))
         begin
            // Each cell has its own balancing bit
            if (s.wstrb[0])
            begin
               next_s.disch = wbyte[5:0]; // RL11
            end
         end
         else if (hit(s.awaddr, cmoc_pkg::IDX_RDSEL))
         begin
            if (s.wstrb[0])
            begin
               next_s.rdsel = wbyte[2:0]; // RL6
            end
         end
         else if (hit(s.awaddr, cmoc_pkg::IDX_LFT))
         begin
            wr_lft = s.wstrb[0];
            next_s.lft_period = merge(s.lft_period, wbyte, s.wstrb[0]);
         end
         else if (hit(s.awaddr, cmoc_pkg::IDX_THRESH))
         begin
            next_s.thresh[7:0] = merge(s.thresh[7:0], wbyte, s.wstrb[0]);
            next_s.thresh[15:8] = merge(s.thresh[15:8], s.wdata[15:8],
                                        s.wstrb[1]);
         end
         else
         begin
            // Read-only or unmapped
            next_s.bresp = cmoc_pkg::RESP_SLVERR;
         end
      end
      // Write response taken, accept the next write
      if (s.bvalid && s_axi_bready)
      begin
         next_s.bvalid = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
      end
      // Read decode at the address handshake
      if (rd_hs)
      begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rresp = cmoc_pkg::RESP_OKAY;
         next_s.rdata = '0;
         if (hit(s_axi_araddr, cmoc_pkg::IDX_CTRL))
         begin
            next_s.rdata[7:0] = s.ctrl;
         end
         else if (hit(s_axi_araddr, cmoc_pkg::IDX_OPER))
         begin
            next_s.rdata[7:0] = s.oper;
         end
         else if (hit(s_axi_araddr, cmoc_pkg::IDX_OPSTAT))
         begin
            next_s.rdata[1:0] = s.op_state; // RL10
         end
         else if (hit(s_axi_araddr, cmoc_pkg::IDX_MASK))
         begin
            next_s.rdata[7:0] = s.irq_mask;
         end
         else if (stat_rd)
         begin
            // Reading acknowledges every flag
            next_s.rdata[7:0] = s.status;
            next_s.status = '0; // RL8 RL20 RL23
         end
         else if (hit(s_axi_araddr, cmoc_pkg::IDX_UDVSTAT))
         begin
            next_s.rdata[5:0] = s.udv_chan;
         end
         else if (hit(s_axi_araddr, cmoc_pkg::IDX_DISCH))
         begin
            next_s.rdata[5:0] = s.disch;
         end
         else if (hit(s_axi_araddr, cmoc_pkg::IDX_RDSEL))
         begin
            next_s.rdata[2:0] = s.rdsel;
         end
         else if (hit(s_axi_araddr, cmoc_pkg::IDX_LFT))
         begin
            next_s.rdata[7:0] = s.lft_period;
         end
         else if (hit(s_axi_araddr, cmoc_pkg::IDX_THRESH))
         begin
            next_s.rdata[15:0] = s.thresh;
         end
         else if (hit(s_axi_araddr, cmoc_pkg::IDX_SINGLE))
         begin
            // Selected channel; codes above six read zero
            if (s.rdsel <= cmoc_pkg::CH_TEMP)
            begin
               next_s.rdata[15:0] = s.res[s.rdsel]; // RL6
            end
         end
         else
         begin
            next_s.rresp = cmoc_pkg::RESP_SLVERR;
            // Burst words: two results per word except the last, which holds only the temperature; lower channel low
            for (int w = 0; w < cmoc_pkg::BURST_WORDS; w++)
            begin
               if (hit(s_axi_araddr, 8'(cmoc_pkg::IDX_BURST + w)))
               begin
                  next_s.rresp = cmoc_pkg::RESP_OKAY;
                  next_s.rdata[15:0] = s.res[2 * w]; // RL5
                  if (w < 3)
                  begin
                     next_s.rdata[31:16] = s.res[2 * w + 1]; // RL5
                  end
               end
            end
         end
      end
      // Read data taken
      if (s.rvalid && s_axi_rready)
      begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end
      // Operation request, start or abort
      if (wr_oper)
      begin
         next_s.oper = wbyte;
         if (!wbyte[cmoc_pkg::OPER_RQ])
         begin
            if (s.seq != cmoc_pkg::SQ_IDLE)
            begin
               // Abort drops the run without any flag
               next_s.seq = cmoc_pkg::SQ_IDLE; // RL9 RL21
               next_s.adc.req = 1'b0;
               next_s.op_state = cmoc_pkg::OPS_ABORT;
            end
            else
            begin
               next_s.op_state = cmoc_pkg::OPS_NONE; // RL21
            end
         end
         else if (s.seq == cmoc_pkg::SQ_IDLE &&
                  !s.status[cmoc_pkg::STAT_RDY])
         begin
            // Start only once the last result is acknowledged
            next_s.seq = cmoc_pkg::SQ_CONV; // RL1 RL7 RL21
            next_s.op_state = cmoc_pkg::OPS_RUN;
            next_s.mode = wbyte[cmoc_pkg::OPER_OM +: 2];
            next_s.adc.req = 1'b1;
            next_s.adc.chan = wbyte[cmoc_pkg::OPER_OM + 1] ?
                              cmoc_pkg::CH_TEMP : 3'h0; // RL22
            next_s.adc.cal = (wbyte[cmoc_pkg::OPER_VM +: 2] ==
                              cmoc_pkg::VM_CAL); // RL3
            next_s.adc.temp_sel = wbyte[cmoc_pkg::OPER_TM]; // RL2
         end
      end
      else
      begin
         case (s.seq)
            cmoc_pkg::SQ_CONV:
            begin
               // Store each result, step through the channels
               if (adc_ack)
               begin
                  next_s.res[s.adc.chan] = adc_data; // RL2
                  if (s.adc.chan == cmoc_pkg::CH_TEMP ||
                      (s.mode == cmoc_pkg::OM_VOLT &&
                       s.adc.chan == cmoc_pkg::CH_LAST_V))
                  begin
                     next_s.seq = cmoc_pkg::SQ_DONE; // RL22
                     next_s.adc.req = 1'b0;
                  end
                  else
                  begin
                     next_s.adc.chan = s.adc.chan + 3'h1;
                  end
               end
            end
            cmoc_pkg::SQ_DONE:
            begin
               // End of run: flag ready, check undervoltage unless temperature only
               next_s.seq = cmoc_pkg::SQ_IDLE;
               next_s.op_state = cmoc_pkg::OPS_END;
               next_s.status[cmoc_pkg::STAT_RDY] = 1'b1; // RL4
               if (!s.mode[1])
               begin
                  next_s.udv_chan = under; // RL18
                  if (under == 6'h00)
                  begin
                     next_s.armed = 1'b1; // RL20
                  end
                  else if (s.armed)
                  begin
                     next_s.status[cmoc_pkg::STAT_UDV] = 1'b1; // RL18
                     next_s.armed = 1'b0; // RL20
                  end
               end
            end
            default:
            begin
               next_s.seq = cmoc_pkg::SQ_IDLE; // RL1
            end
         endcase
      end
      // Low frequency timer on the 50 kHz tick
      if (wr_rstr && wbyte[cmoc_pkg::RSTR_LFT])
      begin
         next_s.lft_cnt = '0; // RL16
         next_s.pre_cnt = '0;
      end
      else if (wr_lft && wbyte < s.lft_cnt)
      begin
         next_s.lft_cnt = '0; // RL15
      end
      else if (s.ctrl[cmoc_pkg::CTRL_LFT_EN])
      begin
         // Runs only while enabled
         if (s.pre_cnt == TICK_LAST)
         begin
            next_s.pre_cnt = '0; // RL12
            if (s.lft_cnt >= s.lft_period)
            begin
               next_s.lft_cnt = '0;
               next_s.status[cmoc_pkg::STAT_LFT] = 1'b1; // RL13 RL23
            end
            else
            begin
               next_s.lft_cnt = s.lft_cnt + 8'h01;
            end
         end
         else
         begin
            next_s.pre_cnt = s.pre_cnt + 10'h001; // RL14
         end
      end
      // Unmasked flags drive the interrupt
      next_s.irq = |(next_s.status & ~next_s.irq_mask &
                     cmoc_pkg::IRQ_SRC); // RL8 RL13 RL18
   end

   // State register, frozen while ce is low
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= cmoc_pkg::state_reset(); // RL1 RL14 RL19
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bresp = s.bresp;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_arready = s.arready;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rvalid = s.rvalid;
   assign adc = s.adc;
   assign discharge = s.disch;
   assign irq = s.irq;

   // Converter busy only during a run
   a_conv_running: assert property (@(posedge clk) disable iff (!rst_n)
      s.adc.req |-> s.op_state == cmoc_pkg::OPS_RUN) // RL1
      else $error("converter busy outside a run");
   // End of run flags result ready
   a_done_ready: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && s.seq == cmoc_pkg::SQ_DONE && !wr_oper) |=>
      s.status[cmoc_pkg::STAT_RDY] && s.op_state == cmoc_pkg::OPS_END) // RL4
      else $error("result ready not raised");
   // Unacknowledged result blocks a start
   a_start_block: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && s.seq == cmoc_pkg::SQ_IDLE && s.status[cmoc_pkg::STAT_RDY]
       && !stat_rd) |=> s.seq == cmoc_pkg::SQ_IDLE) // RL7
      else $error("start while unacknowledged");
   // Status read acknowledges
   a_ack_clears: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && stat_rd && s.seq != cmoc_pkg::SQ_DONE) |=>
      !s.status[cmoc_pkg::STAT_RDY] && !s.status[cmoc_pkg::STAT_UDV])
      // RL8
      else $error("status read left a flag");
   // Abort leaves no flag
   a_abort_run: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && wr_oper && !wbyte[cmoc_pkg::OPER_RQ] &&
       s.seq != cmoc_pkg::SQ_IDLE && !s.status[cmoc_pkg::STAT_RDY]) |=>
      s.seq == cmoc_pkg::SQ_IDLE && s.op_state == cmoc_pkg::OPS_ABORT
      && !s.status[cmoc_pkg::STAT_RDY] ##1 !s.status[cmoc_pkg::STAT_RDY])
      // RL9
      else $error("abort misbehaved");
   // Interrupt is the masked flag set
   a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
      irq == |(s.status & ~s.irq_mask & cmoc_pkg::IRQ_SRC)) // RL13
      else $error("interrupt does not match flags");
   // Disabled timer holds its count
   a_lft_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && !s.ctrl[cmoc_pkg::CTRL_LFT_EN]) |=>
      (s.lft_cnt == $past(s.lft_cnt) || s.lft_cnt == 8'h00)) // RL14
      else $error("disabled timer moved");
   // Shorter period restarts the count
   a_lft_period: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && wr_lft && wbyte < s.lft_cnt) |=> s.lft_cnt == 8'h00) // RL15
      else $error("period write did not restart");
   // Restart bit clears the timer
   a_lft_restart: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && wr_rstr && wbyte[cmoc_pkg::RSTR_LFT]) |=>
      s.lft_cnt == 8'h00 && s.pre_cnt == 10'h000) // RL16
      else $error("timer restart failed");
   // Disarmed undervoltage raises no flag
   a_udv_rearm: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && s.seq == cmoc_pkg::SQ_DONE && !s.armed && !wr_oper &&
       !s.status[cmoc_pkg::STAT_UDV]) |=>
      !s.status[cmoc_pkg::STAT_UDV]) // RL20
      else $error("undervoltage flag without rearm");
endmodule : cmoc_top

//--- cmoc_adc_model.sv
// Converter front-end model answering the block's sample requests.
// Assumes clk shared with the block; lag sets the wait before each answer.
`timescale 1ns/100ps
module cmoc_adc_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire cmoc_pkg::cmoc_adc_s adc,
   input wire logic [3:0] lag,
   input wire logic [15:0] base,
   output logic adc_ack,
   output logic [15:0] adc_data
);
   logic [3:0] cnt; // Cycles waited on the current request
   // Answer after lag cycles; data is base plus the channel number
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= '0;
         adc_ack <= 1'b0;
         adc_data <= '0;
      end
      else if (adc.req && !adc_ack && cnt >= lag)
      begin
         adc_ack <= 1'b1;
         adc_data <= base + 16'(adc.chan);
         cnt <= '0;
      end
      else
      begin
         // Data only holds with ack; scramble it so stale use shows
         adc_ack <= 1'b0;
         adc_data <= ~adc_data;
         cnt <= (adc.req && !adc_ack) ? cnt + 4'h1 : '0;
      end
   end
endmodule : cmoc_adc_model

//--- tb_top.sv
// Self-checking bench: AXI4-Lite master, converter model, timer, balance.
// Assumes the block's own assertions run alongside.
`timescale 1ns/100ps
module tb_top;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, adc_ack;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v, sel;
   logic [1:0] bresp, rresp, r;
   logic [3:0] lag;
   logic [15:0] base, adc_data;
   logic [5:0] discharge;
   cmoc_pkg::cmoc_adc_s adc;
   int n_errors = 0, checks = 0;
   // Clock of 40 ns
   initial
   begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   cmoc_top #(.TICK_CYCLES(4)) uut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .adc(adc),
      .adc_ack(adc_ack), .adc_data(adc_data), .discharge(discharge),
      .irq(irq));
   cmoc_adc_model fe (.clk(clk), .rst_n(rst_n), .adc(adc), .lag(lag),
      .base(base), .adc_ack(adc_ack), .adc_data(adc_data));
   // Byte address of a register index
   function automatic logic [11:0] ad(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction : ad
   // Expected burst word k for data base plus channel
   function automatic logic [31:0] bw(input logic [15:0] b, input int k);
      if (k == 3)
         return {16'h0000, b + 16'h0006};
      return {b + 16'(2 * k + 1), b + 16'(2 * k)};
   endfunction : bw
   // Compare and count
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, s, e);
      end
   endtask : chk
   // AXI4-Lite write; address and data released as each is taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      do
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while (!bvalid);
      r = bresp;
      bready <= 0;
   endtask : wr
   // AXI4-Lite read
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask : rd
   // Wait for the interrupt, bounded
   task automatic wirq();
      for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clk);
   endtask : wirq
   task automatic summarize();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize
   // Watchdog far beyond the expected run length
   initial
   begin
      #2000000;
      n_errors++;
      summarize();
   end
   // Main sequence
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0; araddr = '0; wdata = '0; lag = '0; base = '0;
      rst_n = 0;
      void'($urandom(80665));
      repeat (4) @(posedge clk);
      rst_n <= 1;
      rd(ad(cmoc_pkg::IDX_THRESH), v); chk(v, 32'h0000_05dc);
      rd(ad(cmoc_pkg::IDX_OPSTAT), v); chk(v, 32'h0000_0000);
      chk(irq, 1'b0);
      // Each acquisition selection: completion, flag, acknowledge
      for (int m = 0; m < 3; m++)
      begin
         base <= 16'h0800 + 16'($urandom % 2048);
         lag <= 4'($urandom % 4);
         wr(ad(cmoc_pkg::IDX_OPER), 32'(m * 16 + 3));
         wirq(); chk(irq, 1'b1);
         rd(ad(cmoc_pkg::IDX_STATUS), v); chk(v, 32'h0000_0001);
         repeat (2) @(posedge clk);
         chk(irq, 1'b0);
         rd(ad(cmoc_pkg::IDX_OPSTAT), v); chk(v, 32'h0000_0003);
         if (m == 0)
            for (int k = 0; k < 4; k++)
            begin
               rd(ad(cmoc_pkg::IDX_BURST + 8'(k)), v);
               chk(v, bw(base, k));
            end
         sel = 32'($urandom % 7);
         wr(ad(cmoc_pkg::IDX_RDSEL), sel);
         if (m == 0)
         begin
            rd(ad(cmoc_pkg::IDX_SINGLE), v);
            chk(v, 32'(base + sel[15:0]));
         end
         $display("run mode %0d done", m);
      end
      // Second start before acknowledge is refused
      wr(ad(cmoc_pkg::IDX_OPER), 32'h0000_0003);
      wirq();
      wr(ad(cmoc_pkg::IDX_OPER), 32'h0000_0003);
      repeat (4) @(posedge clk);
      chk(adc.req, 1'b0);
      rd(ad(cmoc_pkg::IDX_STATUS), v); chk(v, 32'h0000_0001);
      // Slow calibration run aborted midway
      lag <= 4'hf;
      wr(ad(cmoc_pkg::IDX_OPER), 32'h0000_0009);
      chk(adc.cal, 1'b1);
      chk(adc.temp_sel, 1'b1);
      wr(ad(cmoc_pkg::IDX_OPER), 32'h0000_0000);
      rd(ad(cmoc_pkg::IDX_OPSTAT), v); chk(v, 32'h0000_0002);
      repeat (60) @(posedge clk);
      chk(irq, 1'b0);
      rd(ad(cmoc_pkg::IDX_STATUS), v); chk(v, 32'h0000_0000);
      $display("abort done");
      // Undervoltage twice: second stays quiet until rearmed
      lag <= 4'h0; base <= 16'h0100;
      for (int n = 0; n < 2; n++)
      begin
         wr(ad(cmoc_pkg::IDX_OPER), 32'h0000_0013);
         wirq();
         rd(ad(cmoc_pkg::IDX_STATUS), v);
         chk(v, n ? 32'h1 : 32'h5);
      end
      rd(ad(cmoc_pkg::IDX_UDVSTAT), v); chk(v, 32'h0000_003f);
      // Balancing bits
      v = 32'($urandom % 64);
      wr(ad(cmoc_pkg::IDX_DISCH), v);
      chk(discharge, v[5:0]);
      // Timer: off until enabled, then elapses; masked stays quiet
      wr(ad(cmoc_pkg::IDX_LFT), 32'h0000_0002);
      repeat (40) @(posedge clk);
      chk(irq, 1'b0);
      wr(ad(cmoc_pkg::IDX_CTRL), 32'h0000_0008);
      wirq();
      rd(ad(cmoc_pkg::IDX_STATUS), v); chk(v, 32'h0000_0002);
      wr(ad(cmoc_pkg::IDX_MASK), 32'h0000_0002);
      rd(ad(cmoc_pkg::IDX_STATUS), v);
      repeat (40) @(posedge clk);
      chk(irq, 1'b0);
      wr(12'h300, 32'h0000_0001); chk(r, cmoc_pkg::RESP_SLVERR);
      rd(ad(cmoc_pkg::IDX_RSTR), v);
      chk(r, cmoc_pkg::RESP_SLVERR);
      wr(ad(cmoc_pkg::IDX_LFT), 32'h0000_0000);
      wr(ad(cmoc_pkg::IDX_RSTR), 32'h0000_0001);
      $display("timer and bus done");
      summarize();
   end
endmodule : tb_top
